// ### hdl/qio_pkg.sv
// What this block does
// - quad reads move address and data on all four lanes, four bits per clock
// - quad random read waits four dummy clocks after the mode byte before data
// - quad random read opcode accepted only with the quad lane enable bit set
// - low nibble of the continuation byte is ignored
// - select field 10 makes the next transaction skip the opcode, address first
// - any other select field value brings back normal opcode decoding
// - continuation reset command clears the continuous read state
// - last burst-wrap setting governs every later quad random read
// - wrap confines a burst to an aligned 8/16/32/64-byte section of a page
// - wrap output starts at given address, returns to section start until deselect
// - three wrap bits: bit 4 disables wrapping, bits 6:5 pick the length
// - word read waits exactly two dummy clocks after the mode byte
// - word read opcode accepted only with the quad lane enable bit set
// - word read with select field 10 makes the next one opcode-free
// - stored wrap setting also governs word reads
// - octal-word read drives data right after the mode byte, no dummy clocks
// - octal-word read opcode accepted only with the quad lane enable bit set
// - octal-word read with select field 10 makes the next one opcode-free
// - eight clocks of all ones leave continuous mode as if select bit 4 were set
// - wrap disable bit resets to one, so reads run linearly
package qio_pkg;

  // opcodes
  localparam logic [7:0] OP_QUAD_READ  = 8'hEB;
  localparam logic [7:0] OP_WORD_READ  = 8'hE7;
  localparam logic [7:0] OP_OCTAL_READ = 8'hE3;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;

  // last count of each phase (bits for opcode, nibbles otherwise)
  localparam logic [2:0] OPC_LAST  = 3'h7;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [2:0] MODE_LAST = 3'h1;
  localparam logic [2:0] WRAP_LAST = 3'h7;

  // dummy clocks per read kind
  localparam logic [2:0] DUMMY_QUAD  = 3'h4;
  localparam logic [2:0] DUMMY_WORD  = 3'h2;
  localparam logic [2:0] DUMMY_OCTAL = 3'h0;

  // continuation byte and wrap byte fields
  localparam logic [1:0] CONT_KEEP    = 2'h2;
  localparam int         CONT_SEL_LSB = 4;
  localparam int         WRAP_DIS_POS = 4;
  localparam int         WRAP_LEN_LSB = 5;
  localparam logic [23:0] SECTION_MIN = 24'h000008;

  // sizes
  localparam int ADDR_W     = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8;

  typedef enum logic [1:0] {
    RD_QUAD  = 2'h0,
    RD_WORD  = 2'h1,
    RD_OCTAL = 2'h2
  } read_kind_t;

  // gray along idle, opcode, address, mode, dummy, data
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_ADDR  = 3'b011,
    ST_MODE  = 3'b010,
    ST_DUMMY = 3'b110,
    ST_DATA  = 3'b111,
    ST_WRAP  = 3'b101,
    ST_IGN   = 3'b100
  } state_t;

  typedef struct packed {
    logic [1:0] len;
    logic       dis;
  } wrap_cfg_t;

  localparam wrap_cfg_t WRAP_RESET = '{len: 2'h0, dis: 1'b1};

  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] lane;
  } qio_pins_t;

  typedef struct packed {
    logic [3:0] lane;
    logic [3:0] oe;
  } qio_drive_t;

  localparam qio_drive_t DRIVE_OFF = '{lane: 4'hF, oe: 4'h0};

endpackage

// ### hdl/quad_io_read_continuous_wrap.sv
`timescale 1ns/1ps
`default_nettype none

// byte prefetch buffer between memory and the lane shifter
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // honest full and empty
  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    wr_d  = push ? wr_q + PW'(1'b1) : wr_q;
    rd_d  = pop ? rd_q + PW'(1'b1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // byte_fifo

module quad_io_read_continuous_wrap
  import qio_pkg::*;
#(
  parameter int PREFETCH_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // serial pins, raw from the pads
  input  wire qio_pins_t           pins_in,
  output logic [3:0]               lane_out,
  output logic [3:0]               lane_oe,
  // status register bit from the surrounding device
  input  wire logic                quad_lane_enable_bit,
  // memory byte read port
  output logic                     mem_req_valid,
  input  wire logic                mem_req_ready,
  output logic [ADDR_W-1:0]        mem_req_addr,
  input  wire logic                mem_rsp_valid,
  output logic                     mem_rsp_ready,
  input  wire logic [7:0]          mem_rsp_data,
  // status
  output logic                     continuous_active,
  output wrap_cfg_t                burst_wrap_bits,
  output logic                     opcode_refused,
  output logic                     data_underrun
);

  // next byte address, wrapping inside the selected section
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input wrap_cfg_t w);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = (SECTION_MIN << w.len) - ADDR_W'(1'b1);
    inc  = a + ADDR_W'(1'b1);
    if (w.dis) begin
      next_addr = inc;
    end else begin
      next_addr = (a & ~mask) | (inc & mask);
    end
  endfunction

  function automatic logic [2:0] dummy_of(input read_kind_t k);
    case (k)
      RD_QUAD:  dummy_of = DUMMY_QUAD;
      RD_WORD:  dummy_of = DUMMY_WORD;
      default:  dummy_of = DUMMY_OCTAL;
    endcase
  endfunction

  qio_pins_t          s1_q, s2_q;
  logic               sck_prev_q;
  logic               rise, fall, cs_n;
  state_t             st_q, st_d;
  logic [2:0]         cnt_q, cnt_d;
  logic [7:0]         sh_q, sh_d;
  logic [7:0]         sh_bit, sh_nib;
  read_kind_t         kind_q, kind_d, cont_kind_q, cont_kind_d;
  logic [ADDR_W-1:0]  addr_q, addr_d;
  logic               cont_q, cont_d;
  wrap_cfg_t          wrap_q, wrap_d;
  logic               hi_q, hi_d;
  logic [3:0]         lo_q, lo_d;
  qio_drive_t         drv_q, drv_d;
  logic               refused_q, refused_d;
  logic               under_q, under_d;
  logic               pop, fetch_start;
  logic               fetch_on_q, fetch_on_d;
  logic [ADDR_W-1:0]  fetch_addr_q, fetch_addr_d;
  logic               pend_q, pend_d, stale_q, stale_d;
  logic               fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [7:0]         fifo_out_data;
  logic               req_fire, rsp_fire;

  // two-flop pin synchronisers plus clock history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q       <= '{sck: 1'b0, cs_n: 1'b1, lane: 4'hF};
      s2_q       <= '{sck: 1'b0, cs_n: 1'b1, lane: 4'hF};
      sck_prev_q <= 1'b0;
    end else begin
      s1_q       <= pins_in;
      s2_q       <= s1_q;
      sck_prev_q <= s2_q.sck;
    end
  end

  assign rise   = s2_q.sck & ~sck_prev_q;
  assign fall   = ~s2_q.sck & sck_prev_q;
  assign cs_n   = s2_q.cs_n;
  assign sh_bit = {sh_q[6:0], s2_q.lane[0]};
  assign sh_nib = {sh_q[3:0], s2_q.lane};

  // command sequencer next state
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    sh_d        = sh_q;
    kind_d      = kind_q;
    addr_d      = addr_q;
    cont_d      = cont_q;
    cont_kind_d = cont_kind_q;
    wrap_d      = wrap_q;
    hi_d        = hi_q;
    lo_d        = lo_q;
    drv_d       = drv_q;
    refused_d   = refused_q;
    under_d     = under_q;
    pop         = 1'b0;
    fetch_start = 1'b0;
    if (cs_n) begin
      st_d  = ST_IDLE;
      drv_d = DRIVE_OFF;
    end else begin
      case (st_q)
        ST_IDLE: begin
          cnt_d     = 3'h0;
          hi_d      = 1'b1;
          refused_d = 1'b0;
          under_d   = 1'b0;
          if (cont_q && quad_lane_enable_bit) begin
            st_d   = ST_ADDR;
            kind_d = cont_kind_q;
          end else begin
            st_d = ST_OPC;
          end
        end
        ST_OPC: begin
          if (rise) begin
            sh_d  = sh_bit;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == OPC_LAST) begin
              cnt_d = 3'h0;
              st_d  = ST_IGN;
              case (sh_bit)
                OP_QUAD_READ, OP_WORD_READ, OP_OCTAL_READ: begin
                  if (quad_lane_enable_bit) begin
                    st_d = ST_ADDR;
                  end else begin
                    refused_d = 1'b1;
                  end
                  kind_d = (sh_bit == OP_QUAD_READ) ? RD_QUAD :
                           (sh_bit == OP_WORD_READ) ? RD_WORD : RD_OCTAL;
                end
                OP_SET_WRAP: st_d = ST_WRAP;
                default:     st_d = ST_IGN;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            addr_d = {addr_q[ADDR_W-5:0], s2_q.lane};
            cnt_d  = cnt_q + 3'h1;
            if (cnt_q == ADDR_LAST) begin
              cnt_d       = 3'h0;
              st_d        = ST_MODE;
              fetch_start = 1'b1;
            end
          end
        end
        ST_MODE: begin
          if (rise) begin
            sh_d  = sh_nib;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == MODE_LAST) begin
              cnt_d = 3'h0;
              // only bits 5:4 matter, low nibble ignored
              cont_d      = (sh_nib[CONT_SEL_LSB +: 2] == CONT_KEEP);
              cont_kind_d = kind_q;
              st_d        = (dummy_of(kind_q) == 3'h0) ? ST_DATA : ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (rise) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == dummy_of(kind_q) - 3'h1) begin
              st_d = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // drive on falling edges, high nibble first
          if (fall) begin
            drv_d.oe = 4'hF;
            if (hi_q) begin
              pop        = 1'b1;
              hi_d       = 1'b0;
              drv_d.lane = fifo_out_valid ? fifo_out_data[7:4] : 4'hF;
              lo_d       = fifo_out_data[3:0];
              under_d    = under_q | ~fifo_out_valid;
            end else begin
              hi_d       = 1'b1;
              drv_d.lane = lo_q;
            end
          end
        end
        ST_WRAP: begin
          if (rise) begin
            sh_d  = sh_nib;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == WRAP_LAST) begin
              st_d       = ST_IGN;
              wrap_d.dis = sh_nib[WRAP_DIS_POS];
              wrap_d.len = sh_nib[WRAP_LEN_LSB +: 2];
            end
          end
        end
        ST_IGN: begin
          st_d = ST_IGN;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q        <= ST_IDLE;
      cnt_q       <= 3'h0;
      sh_q        <= 8'h00;
      kind_q      <= RD_QUAD;
      addr_q      <= '0;
      cont_q      <= 1'b0;
      cont_kind_q <= RD_QUAD;
      wrap_q      <= WRAP_RESET;
      hi_q        <= 1'b1;
      lo_q        <= 4'h0;
      drv_q       <= DRIVE_OFF;
      refused_q   <= 1'b0;
      under_q     <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      kind_q      <= kind_d;
      addr_q      <= addr_d;
      cont_q      <= cont_d;
      cont_kind_q <= cont_kind_d;
      wrap_q      <= wrap_d;
      hi_q        <= hi_d;
      lo_q        <= lo_d;
      drv_q       <= drv_d;
      refused_q   <= refused_d;
      under_q     <= under_d;
    end
  end

  // prefetch: one outstanding byte read, stale answers dropped
  assign req_fire      = mem_req_valid & mem_req_ready;
  assign rsp_fire      = mem_rsp_valid & mem_rsp_ready;
  assign mem_req_valid = fetch_on_q & ~pend_q & ~stale_q & fifo_in_ready;
  assign mem_req_addr  = fetch_addr_q;
  assign mem_rsp_ready = stale_q | ~fetch_on_q | fifo_in_ready;
  assign fifo_in_valid = mem_rsp_valid & fetch_on_q & ~stale_q;

  always_comb begin
    fetch_on_d   = fetch_on_q;
    fetch_addr_d = fetch_addr_q;
    pend_d       = pend_q;
    stale_d      = stale_q;
    if (fetch_start) begin
      fetch_on_d   = 1'b1;
      fetch_addr_d = {addr_q[ADDR_W-5:0], s2_q.lane};
    end
    if (req_fire) begin
      pend_d       = 1'b1;
      fetch_addr_d = next_addr(fetch_addr_q, wrap_q);
    end
    if (cs_n) begin
      fetch_on_d = 1'b0;
      if (pend_q) begin
        stale_d = 1'b1;
      end
    end
    if (rsp_fire) begin
      pend_d  = 1'b0;
      stale_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_on_q   <= 1'b0;
      fetch_addr_q <= '0;
      pend_q       <= 1'b0;
      stale_q      <= 1'b0;
    end else begin
      fetch_on_q   <= fetch_on_d;
      fetch_addr_q <= fetch_addr_d;
      pend_q       <= pend_d;
      stale_q      <= stale_d;
    end
  end

  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (PREFETCH_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (cs_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_rsp_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // outputs from flops
  assign lane_out          = drv_q.lane;
  assign lane_oe           = drv_q.oe;
  assign continuous_active = cont_q;
  assign burst_wrap_bits   = wrap_q;
  assign opcode_refused    = refused_q;
  assign data_underrun     = under_q;

endmodule // quad_io_read_continuous_wrap

`default_nettype wire

// ### sim/qio_props.sv
`timescale 1ns/1ps
`default_nettype none

module qio_props
  import qio_pkg::*;
#(
  parameter int PREFETCH_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // lanes
  input wire qio_pins_t         pins_in,
  input wire logic [3:0]        lane_out,
  input wire logic [3:0]        lane_oe,
  input wire logic              quad_lane_enable_bit,
  // memory port
  input wire logic              mem_req_valid,
  input wire logic              mem_req_ready,
  input wire logic [ADDR_W-1:0] mem_req_addr,
  input wire logic              mem_rsp_valid,
  input wire logic              mem_rsp_ready,
  input wire logic [7:0]        mem_rsp_data,
  // status
  input wire logic              continuous_active,
  input wire wrap_cfg_t         burst_wrap_bits,
  input wire logic              opcode_refused,
  input wire logic              data_underrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic        sck_q, cont_q, cont_d, have_q, have_d, acc;
  logic [7:0]  rise_q, rise_d, op_q, op_d;
  logic [23:0] prev_q, prev_d;

  assign acc = mem_req_valid && mem_req_ready;

  // frame tracking from the raw pads
  always_comb begin
    rise_d = rise_q;
    op_d   = op_q;
    cont_d = cont_q;
    prev_d = prev_q;
    have_d = have_q;
    if (pins_in.cs_n) begin
      rise_d = 8'h00;
      have_d = 1'b0;
      cont_d = continuous_active;
    end else if (pins_in.sck && !sck_q && rise_q != 8'hFF) begin
      rise_d = rise_q + 8'h01;
      if (!cont_q && rise_q < 8'h08) op_d = {op_q[6:0], pins_in.lane[0]};
    end
    if (acc) begin
      prev_d = mem_req_addr;
      have_d = !pins_in.cs_n;
    end
  end

  // tracking registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_q  <= 1'b0;
      rise_q <= 8'h00;
      op_q   <= 8'h00;
      cont_q <= 1'b0;
      have_q <= 1'b0;
      prev_q <= 24'h000000;
    end else begin
      sck_q  <= pins_in.sck;
      rise_q <= rise_d;
      op_q   <= op_d;
      cont_q <= cont_d;
      have_q <= have_d;
      prev_q <= prev_d;
    end
  end

  // address after a within the stored wrap setting
  function automatic logic [23:0] next_addr(input logic [23:0] a, input wrap_cfg_t w);
    logic [23:0] m;
    m = (24'h000008 << w.len) - 24'h000001;
    return w.dis ? a + 24'h000001 : (a & ~m) | ((a + 24'h000001) & m);
  endfunction

  // rise count after which data starts
  function automatic int first_rise(input logic [7:0] op, input logic c);
    int d;
    d = (op == 8'hEB) ? 4 : ((op == 8'hE7) ? 2 : 0);
    return (c ? 8 : 16) + d;
  endfunction

  property p_oe_group;
    lane_oe == 4'h0 || lane_oe == 4'hF;
  endproperty
  a_oe_group: assert property (p_oe_group) else $error("lane enables split");

  property p_idle_level;
    lane_oe == 4'h0 |-> lane_out == 4'hF;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle lane level");

  property p_cs_release;
    pins_in.cs_n [*4] |-> lane_oe == 4'h0;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("drive after deselect");

  property p_refused_quiet;
    opcode_refused |-> lane_oe == 4'h0 && !continuous_active;
  endproperty
  a_refused_quiet: assert property (p_refused_quiet) else $error("refused frame drove");

  property p_refused_cause;
    $rose(opcode_refused) |-> !quad_lane_enable_bit;
  endproperty
  a_refused_cause: assert property (p_refused_cause) else $error("refused with enable");

  property p_first_data;
    $rose(lane_oe[0]) |-> rise_q == first_rise(op_q, cont_q);
  endproperty
  a_first_data: assert property (p_first_data) else $error("dummy count");

  property p_next_addr;
    acc && have_q |-> mem_req_addr == next_addr(prev_q, burst_wrap_bits);
  endproperty
  a_next_addr: assert property (p_next_addr) else $error("address order");

  property p_reset_vals;
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> burst_wrap_bits == WRAP_RESET && !continuous_active && lane_oe == 4'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values");

  c_cont: cover property ($rose(continuous_active));
  c_refused: cover property ($rose(opcode_refused));
  c_full: cover property (mem_rsp_valid && !mem_rsp_ready);
  c_wrap: cover property ($rose(lane_oe[0]) && !burst_wrap_bits.dis);
endmodule // qio_props

bind quad_io_read_continuous_wrap qio_props #(.PREFETCH_DEPTH(PREFETCH_DEPTH)) i_qio_props (
  .clk(clk), .sys_rst(sys_rst), .pins_in(pins_in), .lane_out(lane_out), .lane_oe(lane_oe),
  .quad_lane_enable_bit(quad_lane_enable_bit), .mem_req_valid(mem_req_valid),
  .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid),
  .mem_rsp_ready(mem_rsp_ready), .mem_rsp_data(mem_rsp_data),
  .continuous_active(continuous_active), .burst_wrap_bits(burst_wrap_bits),
  .opcode_refused(opcode_refused), .data_underrun(data_underrun));

`default_nettype wire

// ### sim/qio_host.sv
`timescale 1ns/1ps
`default_nettype none

module qio_host
  import qio_pkg::*;
(
  // clock
  input wire logic       clk,
  // device lane drive
  input wire logic [3:0] dev_lane,
  input wire logic [3:0] dev_oe,
  // pads
  output var qio_pins_t  pins
);
  localparam int HALF = 4;
  logic       sck  = 1'b0;
  logic       cs_n = 1'b1;
  logic       hoe  = 1'b0;
  logic [3:0] hval = 4'hF;
  logic [3:0] seen = 4'hF;
  logic [3:0] lvl;

  // wire level; undriven lanes flip every cycle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl[i] = dev_oe[i] ? dev_lane[i] : (hoe ? hval[i] : ~seen[i]);
    end
  end

  // last wire level
  always_ff @(posedge clk) seen <= lvl;

  assign pins = '{sck: sck, cs_n: cs_n, lane: lvl};

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic start();
    cs_n = 1'b0;
    wait_clk(HALF);
  endtask

  // one clock with a nibble on all four lanes, lane 3 on top
  task automatic nib(input logic [3:0] v);
    sck  = 1'b0;
    hoe  = 1'b1;
    hval = v;
    wait_clk(HALF);
    sck = 1'b1;
    wait_clk(HALF);
  endtask

  // opcode on lane 0, top bit first
  task automatic op_out(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) nib({3'h7, op[i]});
  endtask

  // lanes released at the falling edge, sampled at the rise
  task automatic rd(output logic [3:0] v);
    sck = 1'b0;
    hoe = 1'b0;
    wait_clk(HALF);
    v   = lvl;
    sck = 1'b1;
    wait_clk(HALF);
  endtask

  task automatic stop();
    sck = 1'b0;
    hoe = 1'b0;
    wait_clk(HALF);
    cs_n = 1'b1;
    wait_clk(2 * HALF);
  endtask
endmodule // qio_host

`default_nettype wire

// ### sim/quad_io_read_continuous_wrap_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module quad_io_read_continuous_wrap_test
  import qio_pkg::*;
;
  logic              clk, sys_rst, quad_lane_enable_bit;
  qio_pins_t         pins_in;
  logic [3:0]        lane_out, lane_oe;
  logic              mem_req_valid, mem_rsp_ready, continuous_active;
  logic              opcode_refused, data_underrun, req_hit, rsp_hit;
  logic              mem_req_ready = 1'b1;
  logic              mem_rsp_valid = 1'b0;
  logic [7:0]        mem_rsp_data = 8'h00;
  logic [ADDR_W-1:0] mem_req_addr, req_a;
  wrap_cfg_t         burst_wrap_bits;
  logic [1:0]        ew_len = 2'h0;
  logic              ew_dis = 1'b1;
  int                req_cnt = 0;
  int                fill = 0;
  int                err_total = 0;
  int                comparisons = 0;
  logic [7:0]        ops[3] = '{8'hEB, 8'hE7, 8'hE3};
  int                dums[3] = '{4, 2, 0};

  quad_io_read_continuous_wrap #(.PREFETCH_DEPTH(32)) i_quad_io_read_continuous_wrap (
    .clk(clk), .sys_rst(sys_rst), .pins_in(pins_in), .lane_out(lane_out),
    .lane_oe(lane_oe), .quad_lane_enable_bit(quad_lane_enable_bit),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_ready(mem_rsp_ready), .mem_rsp_data(mem_rsp_data),
    .continuous_active(continuous_active), .burst_wrap_bits(burst_wrap_bits),
    .opcode_refused(opcode_refused), .data_underrun(data_underrun));

  qio_host i_qio_host (.clk(clk), .dev_lane(lane_out), .dev_oe(lane_oe), .pins(pins_in));

  function automatic logic [7:0] mval(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // address of byte i of a burst under the expected wrap setting
  function automatic logic [23:0] nth(input logic [23:0] a, input int i);
    logic [23:0] m;
    m = (24'h000008 << ew_len) - 24'h000001;
    return ew_dis ? a + 24'(i) : (a & ~m) | ((a + 24'(i)) & m);
  endfunction

  // byte memory, one cycle latency, request ready every other cycle
  always @(posedge clk) begin
    req_hit = mem_req_valid && mem_req_ready;
    rsp_hit = mem_rsp_valid && mem_rsp_ready;
    req_a = mem_req_addr;
    if (req_hit) req_cnt++;
    #1;
    mem_req_ready = !mem_req_ready;
    if (rsp_hit) mem_rsp_valid = 1'b0;
    if (req_hit) begin
      mem_rsp_valid = 1'b1;
      mem_rsp_data = mval(req_a);
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one read frame, every byte judged against memory
  task automatic frame(input bit opc, input logic [7:0] op, input logic [23:0] a,
                       input logic [7:0] m, input int dum, input int n, input int pause);
    logic [3:0] hi, lo;
    int         n0;
    n0 = req_cnt;
    i_qio_host.start();
    if (opc) i_qio_host.op_out(op);
    for (int i = 5; i >= 0; i--) i_qio_host.nib(a[i*4 +: 4]);
    i_qio_host.nib(m[7:4]);
    i_qio_host.nib(m[3:0]);
    repeat (dum) i_qio_host.rd(hi);
    if (pause > 0) i_qio_host.wait_clk(pause);
    fill = req_cnt - n0;
    for (int i = 0; i < n; i++) begin
      i_qio_host.rd(hi);
      i_qio_host.rd(lo);
      `CHK("read byte", mval(nth(a, i)), {hi, lo})
    end
    `CHK("underrun", 1'b0, data_underrun)
    i_qio_host.stop();
  endtask

  task automatic set_wrap(input logic [1:0] len, input logic dis);
    i_qio_host.start();
    i_qio_host.op_out(8'h77);
    repeat (6) i_qio_host.nib(4'h0);
    i_qio_host.nib({1'b0, len, dis});
    i_qio_host.nib(4'h0);
    i_qio_host.stop();
    ew_len = len;
    ew_dis = dis;
    `CHK("wrap bits", {len, dis}, burst_wrap_bits)
  endtask

  task automatic t_reset();
    `CHK("wrap reset", 3'b001, burst_wrap_bits)
    `CHK("oe reset", 4'h0, lane_oe)
    $display("reset test done");
  endtask

  task automatic t_quad();
    frame(1'b1, 8'hEB, 24'h0123FC, 8'h00, 4, 8, 0);
    `CHK("continuous", 1'b0, continuous_active)
    $display("quad read test done");
  endtask

  task automatic t_refuse();
    quad_lane_enable_bit = 1'b0;
    for (int k = 0; k < 3; k++) begin
      frame(1'b1, ops[k], 24'h000300, 8'hA0, dums[k], 0, 0);
      `CHK("refused", 1'b1, opcode_refused)
      `CHK("continuous", 1'b0, continuous_active)
    end
    quad_lane_enable_bit = 1'b1;
    $display("refuse test done");
  endtask

  task automatic t_wrap();
    for (int l = 0; l < 4; l++) begin
      set_wrap(2'(l), 1'b0);
      frame(1'b1, 8'hEB, 24'h0456A5, 8'h00, 4, (8 << l) + 3, 0);
    end
    frame(1'b1, 8'hE7, 24'h00107A, 8'h00, 2, 20, 0);
    set_wrap(2'h0, 1'b1);
    $display("wrap test done");
  endtask

  task automatic t_cont();
    logic [23:0] a;
    for (int k = 0; k < 3; k++) begin
      a = 24'h002040 + 24'(k) * 24'h000100;
      frame(1'b1, ops[k], a, 8'hA5, dums[k], 3, 0);
      `CHK("armed", 1'b1, continuous_active)
      frame(1'b0, 8'h00, a + 24'h000010, 8'hAA, dums[k], 3, 0);
      `CHK("kept", 1'b1, continuous_active)
      if (k == 0) begin
        frame(1'b0, 8'h00, a + 24'h000020, 8'h5F, dums[k], 3, 0);
      end else begin
        i_qio_host.start();
        repeat (8) i_qio_host.nib(4'hF);
        i_qio_host.stop();
      end
      `CHK("released", 1'b0, continuous_active)
    end
    $display("continuous test done");
  endtask

  task automatic t_stall();
    frame(1'b1, 8'hEB, 24'h000700, 8'h00, 4, 40, 400);
    `CHK("buffer fill", FIFO_DEPTH, fill)
    $display("stall test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    quad_lane_enable_bit = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    i_qio_host.wait_clk(4);
    t_reset();
    t_quad();
    t_refuse();
    t_wrap();
    t_cont();
    t_stall();
    stop_test();
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // quad_io_read_continuous_wrap_test

`default_nettype wire
